/* File: btp_pkg.sv */
// Purpose: Shared constants and types for the binary transfer and poll block
// Assumes: 32-bit APB register bus, byte-wide instrument bus
// Notes: Register offsets are byte addresses, one aligned word each
package btp_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] BTP_OFS_CTRL = 8'h00;
  localparam logic [7:0] BTP_OFS_STATUS = 8'h04;
  localparam logic [7:0] BTP_OFS_EVENT = 8'h08;
  localparam logic [7:0] BTP_OFS_STIDX = 8'h0c;
  localparam logic [7:0] BTP_OFS_STDATA = 8'h10;
  localparam logic [7:0] BTP_OFS_TRIDX = 8'h14;
  localparam logic [7:0] BTP_OFS_TRDATA = 8'h18;

  // ==========================================================
  // Field positions
  localparam int BTP_CTRL_KEYREP = 0;
  localparam int BTP_CTRL_SETTLED = 1;
  localparam int BTP_CTRL_DMODE_LO = 4;
  localparam int BTP_CTRL_PEND = 8;
  localparam int BTP_EVT_SETTLED = 0;
  localparam int BTP_EVT_KEY = 1;
  localparam int BTP_STB_BADCMD = 0;
  localparam int BTP_STB_SETTLED = 1;
  localparam int BTP_STB_KEY = 2;
  localparam int BTP_STB_RSV = 6;
  localparam int BTP_ENT_UNBLANK = 12;
  localparam int BTP_ENT_BLANK = 13;
  localparam int BTP_MAG_W = 10;

  // ==========================================================
  // Values
  localparam logic [7:0] BTP_STB_RST = 8'h00;
  localparam logic [7:0] BTP_STB_CLR_MASK = 8'h47;
  localparam logic [3:0] BTP_DMODE_RST = 4'h0;
  localparam logic [9:0] BTP_MAG_TOP = 10'h3ff;
  localparam logic [9:0] BTP_MAG_REF = 10'h3e8;
  localparam logic [15:0] BTP_LEAD_WORD = 16'hffff;
  localparam logic [7:0] BTP_CHR_CR = 8'h0d;
  localparam logic [7:0] BTP_CHR_LF = 8'h0a;
  localparam logic [6:0] BTP_BUS_SPE = 7'h18;
  localparam logic [6:0] BTP_BUS_SPD = 7'h19;
  localparam int BTP_STATE_WORDS = 100;
  localparam int BTP_TRACE_PAIRS = 1002;

  typedef enum logic [2:0] {
    BTP_CMD_STATE_DUMP,
    BTP_CMD_STATE_LOAD,
    BTP_CMD_FIRST_TRACE_LOAD,
    BTP_CMD_SECOND_TRACE_LOAD,
    BTP_CMD_SECOND_TRACE_DUMP,
    BTP_CMD_UNKNOWN
  } btp_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD_STATE,
    ST_LOAD_TRACE,
    ST_DUMP_STATE,
    ST_DUMP_TRACE
  } btp_state_t;

endpackage

/* File: btp_core.sv */
// Purpose: Binary state/trace transfers, service requests and serial poll status
// Assumes: Bus handshake and ASCII parsing done outside; inputs synchronous to ref_clk
// Notes: Memories are not reset; only the second trace can be dumped
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module btp_core #(
  parameter int STATE_WORDS = btp_pkg::BTP_STATE_WORDS,
  parameter int TRACE_PAIRS = btp_pkg::BTP_TRACE_PAIRS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parsed commands
  input wire logic cmd_valid,
  input wire btp_pkg::btp_cmd_t cmd_code,
  output logic cmd_ready,
  // Received data bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic binary_active,
  // Talker data bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Bus commands and addressing
  input wire logic atn,
  input wire logic bus_cmd_valid,
  input wire logic [7:0] bus_cmd_data,
  input wire logic talk_addressed,
  // Service request and poll
  output logic srq,
  output logic [7:0] status_byte,
  output logic status_drive,
  output logic state_commit
);
  import btp_pkg::*;

  localparam int TRACE_POS = TRACE_PAIRS - 1;
  localparam int CNT_W = $clog2(2 * TRACE_PAIRS + 1);
  localparam logic [CNT_W-1:0] STATE_LAST = CNT_W'(STATE_WORDS - 1);
  localparam logic [CNT_W-1:0] TRACE_LAST = CNT_W'(2 * TRACE_PAIRS - 1);

  if (TRACE_PAIRS < 2 || TRACE_PAIRS > 1024 || STATE_WORDS < 1 || STATE_WORDS > 128) begin : g_bad
    $error("btp_core: unsupported trace or state size");
  end

  // ==========================================================
  // Functions
  // Dump entry: flag bits mark where drawing changes, so replay restores it
  function automatic logic [15:0] enc_entry(input logic [10:0] ent, input logic prev);
    logic [15:0] w;
    w = 16'h0000;
    w[BTP_MAG_W-1:0] = ent[BTP_MAG_W-1:0];
    w[BTP_ENT_UNBLANK] = ent[BTP_MAG_W] & ~prev;
    w[BTP_ENT_BLANK] = ~ent[BTP_MAG_W] & prev;
    return w;
  endfunction

  // ==========================================================
  // Storage and state
  btp_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic first_r;
  logic trace_sel_r;
  logic [7:0] hi_r;
  logic draw_r;
  logic prev_r;
  logic [7:0] active_state [STATE_WORDS];
  logic [7:0] shadow_state [STATE_WORDS];
  logic [7:0] snap_state [STATE_WORDS];
  logic [10:0] trace_mem [2][TRACE_POS];
  logic [7:0] stb_r;
  logic poll_r;
  logic keyrep_r, settled_r, pend_r;
  logic [3:0] dmode_r;
  logic [6:0] stidx_r;
  logic [10:0] tridx_r;
  logic [31:0] prdata_r;
  logic tx_valid_r;
  logic [7:0] tx_data_r;

  logic rx_take, tx_take, cmd_take, skip_eol, byte_use, state_last, tr_we;
  logic [CNT_W-2:0] pair;
  logic [15:0] entry;
  logic draw_nxt;
  logic [10:0] tr_wdata;
  logic spe_pulse, spd_pulse;
  logic [2:0] evt;
  logic apb_wr, apb_rd_setup, addr_ok, start_bin;
  logic [15:0] dump_word;

  // ==========================================================
  // Command and data acceptance
  assign cmd_ready = (st_r == ST_IDLE);
  assign cmd_take = cmd_valid && cmd_ready && (cmd_code != BTP_CMD_UNKNOWN);
  assign rx_ready = (st_r == ST_LOAD_STATE) || (st_r == ST_LOAD_TRACE);
  assign binary_active = (st_r != ST_IDLE);
  assign rx_take = rx_valid && rx_ready;
  assign skip_eol = first_r && (rx_data == BTP_CHR_CR || rx_data == BTP_CHR_LF);
  assign byte_use = rx_take && !skip_eol;
  assign tx_take = tx_valid_r && tx_ready;
  assign start_bin = cmd_take;
  assign state_last = (cnt_r == STATE_LAST);
  assign pair = cnt_r[CNT_W-1:1];

  // Pair joining: first byte is the high half
  assign entry = {hi_r, rx_data};
  // Blank wins if both flags set; a set unblank while drawing changes nothing
  assign draw_nxt = entry[BTP_ENT_BLANK] ? 1'b0 :
                    (entry[BTP_ENT_UNBLANK] ? 1'b1 : draw_r);
  // Bits 10, 11, 14, 15 never reach storage; new draw state applies at this point
  assign tr_wdata = {draw_nxt, entry[BTP_MAG_W-1:0]};
  assign tr_we = byte_use && (st_r == ST_LOAD_TRACE) && cnt_r[0] && (pair != '0);

  // ==========================================================
  // Transfer sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      first_r <= 1'b0;
      trace_sel_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          first_r <= 1'b1;
          if (cmd_take) begin
            unique case (cmd_code)
              BTP_CMD_STATE_DUMP: st_r <= ST_DUMP_STATE;
              BTP_CMD_STATE_LOAD: st_r <= ST_LOAD_STATE;
              BTP_CMD_FIRST_TRACE_LOAD: begin
                st_r <= ST_LOAD_TRACE;
                trace_sel_r <= 1'b0;
              end
              BTP_CMD_SECOND_TRACE_LOAD: begin
                st_r <= ST_LOAD_TRACE;
                trace_sel_r <= 1'b1;
              end
              BTP_CMD_SECOND_TRACE_DUMP: begin
                st_r <= ST_DUMP_TRACE;
                trace_sel_r <= 1'b1;
              end
              default: st_r <= ST_IDLE;
            endcase
          end
        end
        ST_LOAD_STATE, ST_LOAD_TRACE: begin
          if (rx_take) begin
            first_r <= 1'b0;
          end
          if (byte_use) begin
            cnt_r <= cnt_r + 1'b1;
            if ((st_r == ST_LOAD_STATE && state_last) ||
                (st_r == ST_LOAD_TRACE && cnt_r == TRACE_LAST)) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_DUMP_STATE, ST_DUMP_TRACE: begin
          if (tx_take) begin
            cnt_r <= cnt_r + 1'b1;
            if ((st_r == ST_DUMP_STATE && state_last) ||
                (st_r == ST_DUMP_TRACE && cnt_r == TRACE_LAST)) begin
              st_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Instrument state: staged load, snapshot for dump
  assign state_commit = (st_r == ST_LOAD_STATE) && byte_use && state_last;

  always_ff @(posedge ref_clk) begin
    if (st_r == ST_LOAD_STATE && byte_use) begin
      shadow_state[cnt_r[6:0]] <= rx_data;
    end
    if (st_r == ST_IDLE && cmd_take && cmd_code == BTP_CMD_STATE_DUMP) begin
      snap_state <= active_state;
    end
  end

  // Live state changes as a whole on the final load byte, or one byte per APB write to STDATA
  always_ff @(posedge ref_clk) begin
    if (state_commit) begin
      for (int i = 0; i < STATE_WORDS; i++) begin
        active_state[i] <= (i == int'(cnt_r)) ? rx_data : shadow_state[i];
      end
    end else if (apb_wr && paddr == BTP_OFS_STDATA) begin
      active_state[stidx_r] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Trace storage, left to right
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_r <= 8'h00;
      draw_r <= 1'b1;
    end else if (st_r == ST_IDLE) begin
      draw_r <= 1'b1;
    end else if (st_r == ST_LOAD_TRACE && byte_use) begin
      if (!cnt_r[0]) begin
        hi_r <= rx_data;
      end else if (pair != '0) begin
        draw_r <= draw_nxt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (tr_we) begin
      trace_mem[trace_sel_r][pair - 1'b1] <= tr_wdata;
    end
  end

  // ==========================================================
  // Talker output
  assign dump_word = (pair == '0) ? BTP_LEAD_WORD :
                     enc_entry(trace_mem[1][pair - 1'b1], prev_r);
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;

  // One idle cycle per byte keeps the source mux off the handshake path
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      prev_r <= 1'b1;
    end else if (tx_take) begin
      tx_valid_r <= 1'b0;
      if (st_r == ST_DUMP_TRACE && cnt_r[0] && pair != '0) begin
        prev_r <= trace_mem[1][pair - 1'b1][BTP_MAG_W];
      end
    end else if (st_r == ST_DUMP_STATE && !tx_valid_r) begin
      tx_valid_r <= 1'b1;
      tx_data_r <= snap_state[cnt_r[6:0]];
    end else if (st_r == ST_DUMP_TRACE && !tx_valid_r) begin
      tx_valid_r <= 1'b1;
      tx_data_r <= cnt_r[0] ? dump_word[7:0] : dump_word[15:8];
    end else if (st_r == ST_IDLE) begin
      prev_r <= 1'b1;
    end
  end

  // ==========================================================
  // Service request and serial poll
  assign spe_pulse = atn && bus_cmd_valid && bus_cmd_data[6:0] == BTP_BUS_SPE;
  assign spd_pulse = atn && bus_cmd_valid && bus_cmd_data[6:0] == BTP_BUS_SPD;
  assign evt[BTP_STB_BADCMD] = cmd_valid && cmd_code == BTP_CMD_UNKNOWN;
  assign evt[BTP_STB_SETTLED] = apb_wr && paddr == BTP_OFS_EVENT && settled_r &&
                                pwdata[BTP_EVT_SETTLED];
  assign evt[BTP_STB_KEY] = apb_wr && paddr == BTP_OFS_EVENT && keyrep_r && pwdata[BTP_EVT_KEY];

  // A new cause in the disable cycle survives the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stb_r <= BTP_STB_RST;
    end else begin
      stb_r <= (spd_pulse ? (stb_r & ~BTP_STB_CLR_MASK) : stb_r) |
               {1'b0, |evt, 3'b000, evt} & 8'h7f;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_r <= 1'b0;
    end else if (spe_pulse) begin
      poll_r <= 1'b1;
    end else if (spd_pulse) begin
      poll_r <= 1'b0;
    end
  end

  assign srq = stb_r[BTP_STB_RSV];
  assign status_byte = stb_r;
  assign status_drive = poll_r && talk_addressed && !atn;

  // ==========================================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd_setup = psel && !penable;
  assign addr_ok = paddr == BTP_OFS_CTRL || paddr == BTP_OFS_STATUS ||
                   paddr == BTP_OFS_EVENT || paddr == BTP_OFS_STIDX ||
                   paddr == BTP_OFS_STDATA || paddr == BTP_OFS_TRIDX ||
                   paddr == BTP_OFS_TRDATA;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyrep_r <= 1'b0;
      settled_r <= 1'b0;
      dmode_r <= BTP_DMODE_RST;
      pend_r <= 1'b0;
      stidx_r <= '0;
      tridx_r <= '0;
    end else begin
      if (apb_wr && paddr == BTP_OFS_CTRL) begin
        keyrep_r <= pwdata[BTP_CTRL_KEYREP];
        settled_r <= pwdata[BTP_CTRL_SETTLED];
        dmode_r <= pwdata[BTP_CTRL_DMODE_LO +: 4];
      end
      // Dump mode is kept; only the pending request dies with a binary op
      if (start_bin) begin
        pend_r <= 1'b0;
      end else if (apb_wr && paddr == BTP_OFS_CTRL && !binary_active) begin
        pend_r <= pwdata[BTP_CTRL_PEND];
      end
      if (apb_wr && paddr == BTP_OFS_STIDX) begin
        stidx_r <= pwdata[6:0];
      end
      if (apb_wr && paddr == BTP_OFS_TRIDX) begin
        tridx_r <= pwdata[10:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_rd_setup) begin
      prdata_r <= 32'h0000_0000;
      unique case (paddr)
        BTP_OFS_CTRL: prdata_r <= {23'h0, pend_r, dmode_r, 2'b00, settled_r, keyrep_r};
        BTP_OFS_STATUS: prdata_r <= {21'h0, poll_r, binary_active, srq, stb_r};
        BTP_OFS_STIDX: prdata_r <= {25'h0, stidx_r};
        BTP_OFS_STDATA: prdata_r <= {24'h0, active_state[stidx_r]};
        BTP_OFS_TRIDX: prdata_r <= {21'h0, tridx_r};
        BTP_OFS_TRDATA: prdata_r <= {21'h0, trace_mem[tridx_r[10]][tridx_r[9:0]]};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  chk_commit_last: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_commit |=> st_r == ST_IDLE && $past(cnt_r) == STATE_LAST)
    else $error("state commit not on last byte");
  chk_state_dump_end: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r == ST_DUMP_STATE && tx_take && cnt_r == STATE_LAST) |=> st_r == ST_IDLE)
    else $error("state dump length wrong");
  chk_trace_dump_end: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r == ST_DUMP_TRACE && tx_take) |=> (st_r == ST_IDLE) == ($past(cnt_r) == TRACE_LAST))
    else $error("trace dump length wrong");
  chk_lead_discard: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r == ST_LOAD_TRACE && byte_use && cnt_r < CNT_W'(2)) |-> !tr_we)
    else $error("leading pair stored");
  // Byte taken just before the current one, whatever the spacing of the stream
  logic [7:0] chk_prev_byte_r;
  always_ff @(posedge ref_clk) begin
    if (st_r == ST_LOAD_TRACE && byte_use) begin
      chk_prev_byte_r <= rx_data;
    end
  end
  chk_pair_join: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tr_we |-> tr_wdata[9:0] == {chk_prev_byte_r[1:0], rx_data})
    else $error("pair join order wrong");
  chk_blank_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tr_we && hi_r[5]) |-> !tr_wdata[10] ##1 !draw_r)
    else $error("blank flag not applied");
  chk_unblank_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tr_we && hi_r[4] && !hi_r[5]) |-> tr_wdata[10])
    else $error("unblank flag not applied");
  chk_eol_skip: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rx_take && skip_eol) |=> cnt_r == $past(cnt_r))
    else $error("leading line end counted");
  chk_srq_cause: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(srq) |-> $past(|evt))
    else $error("service request without cause");
  chk_spd_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (spd_pulse && evt == 3'b000) |=> (stb_r & BTP_STB_CLR_MASK) == 8'h00 && !srq)
    else $error("poll disable did not clear");
  chk_pend_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_bin |=> !pend_r && dmode_r == $past(dmode_r))
    else $error("pending dump survived binary op");
endmodule

/* File: btp_ctrl_model.sv */
// Purpose: Behavioural bus controller issuing commands, bytes and serial polls
// Assumes: The bench calls one task at a time, just after a rising edge
// Notes: Released data lines change value, so a stale byte is never read as valid
`timescale 1ns/1ps
module btp_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Commands and byte streams
  output logic cmd_valid,
  output btp_pkg::btp_cmd_t cmd_code,
  input wire logic cmd_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Bus management and poll
  output logic atn,
  output logic bus_cmd_valid,
  output logic [7:0] bus_cmd_data,
  output logic talk_addressed,
  input wire logic [7:0] status_byte,
  input wire logic status_drive,
  // Wait bound used up
  output logic hung
);
  import btp_pkg::*;
  logic [7:0] snap;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = BTP_CMD_UNKNOWN;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    atn = 1'b0;
    bus_cmd_valid = 1'b0;
    bus_cmd_data = 8'h00;
    talk_addressed = 1'b0;
    hung = 1'b0;
  end
  // ==========================================================
  // Sample at the falling edge so the next rising edge is the taking one
  task automatic wait_sig(input int s);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (((s == 0) ? cmd_ready : (s == 1) ? rx_ready : tx_valid) !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 3000) hung = 1'b1;
    snap = tx_data;
    @(posedge ref_clk);
  endtask
  task automatic send_cmd(input btp_cmd_t c);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    wait_sig(0);
    cmd_valid <= 1'b0;
    cmd_code <= BTP_CMD_UNKNOWN;
  endtask
  // No sweep or calibration command is ever sent, so loaded traces survive
  // Calibration control lies outside this block, none is issued between commands
  // Bytes go out in the order handed over, never reordered
  task automatic send_byte(input logic [7:0] v);
    rx_valid <= 1'b1;
    rx_data <= v;
    wait_sig(1);
  endtask
  task automatic end_bytes();
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // A slow talker read stalls tx_ready for three cycles first
  // Ready stays low until the first read, so an unread dump never drains
  task automatic recv_byte(input logic slow, output logic [7:0] v);
    if (slow) begin
      tx_ready <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    tx_ready <= 1'b1;
    wait_sig(2);
    v = snap;
  endtask
  // ==========================================================
  // Serial poll; bit 7 of the enable code is set to show it is ignored
  task automatic poll(output logic [7:0] stb, output logic drv);
    atn <= 1'b1;
    bus_cmd_valid <= 1'b1;
    bus_cmd_data <= {1'b1, BTP_BUS_SPE};
    @(posedge ref_clk);
    bus_cmd_valid <= 1'b0;
    bus_cmd_data <= 8'h5a;
    talk_addressed <= 1'b1;
    @(posedge ref_clk);
    atn <= 1'b0;
    @(negedge ref_clk);
    stb = status_byte;
    drv = status_drive;
    @(posedge ref_clk);
    atn <= 1'b1;
    talk_addressed <= 1'b0;
    bus_cmd_valid <= 1'b1;
    bus_cmd_data <= {1'b0, BTP_BUS_SPD};
    @(posedge ref_clk);
    bus_cmd_valid <= 1'b0;
    bus_cmd_data <= 8'ha5;
    @(posedge ref_clk);
    atn <= 1'b0;
  endtask
endmodule

/* File: btp_core_tb.sv */
// Purpose: Self-checking bench for binary transfers, service requests and polls
// Assumes: Controller model supplies commands, bytes and serial polls
// Notes: Trace contents are read back over APB after each load
`timescale 1ns/1ps
module btp_core_tb;
  import btp_pkg::*;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr, rx_data, tx_data, bus_cmd_data, status_byte, b, stb;
  logic [31:0] pwdata, prdata, rd;
  logic cmd_valid, cmd_ready, rx_valid, rx_ready, binary_active, tx_valid, tx_ready;
  logic atn, bus_cmd_valid, talk_addressed, srq, status_drive, state_commit, hung, drv, on;
  btp_cmd_t cmd_code;
  logic [15:0] e;
  logic drawn [1001];
  int err_count = 0;
  int total_checks = 0;
  int commits = 0;
  logic apb_hung = 1'b0;

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    if (state_commit === 1'b1) commits++;
  end

  btp_core dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .binary_active(binary_active), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .atn(atn), .bus_cmd_valid(bus_cmd_valid),
    .bus_cmd_data(bus_cmd_data), .talk_addressed(talk_addressed), .srq(srq),
    .status_byte(status_byte), .status_drive(status_drive), .state_commit(state_commit)
  );
  btp_ctrl_model ctl (
    .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .atn(atn), .bus_cmd_valid(bus_cmd_valid),
    .bus_cmd_data(bus_cmd_data), .talk_addressed(talk_addressed),
    .status_byte(status_byte), .status_drive(status_drive), .hung(hung)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (hung === 1'b1 || apb_hung === 1'b1) err_count++;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One idle cycle after each transfer keeps two setups from sharing a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) apb_hung = 1'b1;
    @(posedge ref_clk);
  endtask
  // Entry pattern: odd positions carry junk in the ignored bits; flags never both set
  function automatic logic [15:0] mk(input int p, input int s);
    logic [15:0] v;
    v = 16'((p * 7 + s) % 1024);
    if (p == 1) v = {6'h00, BTP_MAG_TOP};
    if (p == 2) v = {6'h00, BTP_MAG_REF};
    if (p % 2 == 1) v = v | 16'hcc00;
    if (s == 0 && (p == 5 || p == 20)) v[BTP_ENT_UNBLANK] = 1'b1;
    if (s == 0 && (p == 10 || p == 30)) v[BTP_ENT_BLANK] = 1'b1;
    return v;
  endfunction
  task automatic trace_load(input btp_cmd_t c, input int s, input logic cr);
    ctl.send_cmd(c);
    if (cr) ctl.send_byte(BTP_CHR_CR);
    ctl.send_byte(BTP_LEAD_WORD[15:8]);
    ctl.send_byte(BTP_LEAD_WORD[7:0]);
    for (int p = 0; p < 1001; p++) begin
      e = mk(p, s);
      ctl.send_byte(e[15:8]);
      ctl.send_byte(e[7:0]);
    end
    ctl.end_bytes();
  endtask

  initial begin
    for (int n = 0; n < 100000 && hung !== 1'b1 && apb_hung !== 1'b1; n++) @(posedge ref_clk);
    err_count++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({srq, status_byte, cmd_ready, rx_ready, binary_active, tx_valid, state_commit}, 32'h10);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    apb(1'b1, BTP_OFS_CTRL, 32'h158);
    apb(1'b0, BTP_OFS_CTRL, 32'h0);
    chk(rd, 32'h150);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    chk(perr, 32'h1);
    apb(1'b0, BTP_OFS_EVENT, 32'h0);
    chk(rd, 32'h0);
    // State load with a leading line feed, commit only on the last byte
    ctl.send_cmd(BTP_CMD_STATE_LOAD);
    ctl.send_byte(BTP_CHR_LF);
    for (int i = 0; i < 100; i++) begin
      if (i == 99) chk(commits, 32'h0);
      ctl.send_byte(8'(i * 3 + 1));
    end
    ctl.end_bytes();
    chk(commits, 32'h1);
    apb(1'b0, BTP_OFS_STATUS, 32'h0);
    chk(rd[9], 32'h0);
    apb(1'b1, BTP_OFS_STIDX, 32'h7);
    apb(1'b0, BTP_OFS_STDATA, 32'h0);
    chk(rd, 32'h16);
    apb(1'b1, BTP_OFS_STIDX, 32'h3);
    apb(1'b1, BTP_OFS_STDATA, 32'h5a);
    // State dump snapshots the live state and keeps the dump mode
    apb(1'b1, BTP_OFS_CTRL, 32'h150);
    ctl.send_cmd(BTP_CMD_STATE_DUMP);
    apb(1'b0, BTP_OFS_CTRL, 32'h0);
    chk(rd, 32'h50);
    for (int i = 0; i < 100; i++) begin
      ctl.recv_byte(i % 3 == 0, b);
      chk(b, (i == 3) ? 8'h5a : 8'(i * 3 + 1));
    end
    // Second trace with flags, then first trace, then dump of the second
    trace_load(BTP_CMD_SECOND_TRACE_LOAD, 0, 1'b1);
    on = 1'b1;
    for (int p = 0; p < 1001; p++) begin
      e = mk(p, 0);
      if (e[BTP_ENT_BLANK]) on = 1'b0;
      else if (e[BTP_ENT_UNBLANK]) on = 1'b1;
      drawn[p] = on;
      apb(1'b1, BTP_OFS_TRIDX, {21'h0, 1'b1, 10'(p)});
      apb(1'b0, BTP_OFS_TRDATA, 32'h0);
      chk(rd, {21'h0, drawn[p], e[9:0]});
    end
    trace_load(BTP_CMD_FIRST_TRACE_LOAD, 3, 1'b0);
    for (int p = 0; p < 1001; p += 500) begin
      apb(1'b1, BTP_OFS_TRIDX, {22'h0, 10'(p)});
      apb(1'b0, BTP_OFS_TRDATA, 32'h0);
      e = mk(p, 3);
      chk(rd, {21'h0, 1'b1, e[9:0]});
    end
    ctl.send_cmd(BTP_CMD_SECOND_TRACE_DUMP);
    for (int i = 0; i < 2; i++) begin
      ctl.recv_byte(1'b1, b);
      chk(b, 8'hff);
    end
    for (int p = 0; p < 1001; p++) begin
      e = mk(p, 0);
      on = (p == 0) ? 1'b1 : drawn[p - 1];
      e = {2'b00, on & ~drawn[p], ~on & drawn[p], 2'b00, e[9:0]};
      ctl.recv_byte(p % 7 == 0, b);
      chk(b, e[15:8]);
      ctl.recv_byte(1'b0, b);
      chk(b, e[7:0]);
    end
    // Service requests and serial polls
    ctl.send_cmd(BTP_CMD_UNKNOWN);
    @(posedge ref_clk);
    apb(1'b0, BTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h141);
    ctl.poll(stb, drv);
    chk({drv, stb}, 32'h141);
    apb(1'b0, BTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, BTP_OFS_CTRL, 32'h0);
    apb(1'b1, BTP_OFS_EVENT, 32'h3);
    apb(1'b0, BTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, BTP_OFS_CTRL, 32'h3);
    apb(1'b1, BTP_OFS_EVENT, 32'h1);
    apb(1'b0, BTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h142);
    apb(1'b1, BTP_OFS_EVENT, 32'h2);
    ctl.poll(stb, drv);
    chk({drv, stb}, 32'h146);
    apb(1'b0, BTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(status_drive, 32'h0);
    finish_test();
  end
endmodule
